// ==== sdr_pkg.sv ====
// Package: constants and carrier types for the serial video receive back end
package sdr_pkg;
    localparam int WORD_W = 10;                      // Parallel word width
    localparam int DIV_RATIO = 10;                   // Bit clocks per word
    localparam logic [3:0] DIV_INIT = 4'h0;          // Divider initial state
    localparam logic [3:0] DIV_LAST = 4'h9;          // Divider terminal count
    localparam logic [3:0] DIV_READOUT = 4'h0;       // Phase of readout strobe
    localparam logic [3:0] DIV_HALF = 4'h5;          // Phase of word clock fall
    localparam logic [8:0] SCR_INIT = 9'h000;        // Descrambler history reset
    localparam logic [9:0] TRS_ONES = 10'h3FF;       // Preamble first word
    localparam logic [9:0] TRS_ZEROS = 10'h000;      // Preamble second and third word
    localparam int H_BIT = 6;                        // H flag position in header word
    localparam int TAP_HI = 8;                       // Scrambler tap x^9
    localparam int TAP_LO = 3;                       // Scrambler tap x^4
    localparam int BIT_RATE_HZ = 270000000;          // Recovered bit clock rate
    localparam int LOCK_DELAY_US = 38;               // Lock rise delay
    localparam int LOCK_DROP_US = 64;                // Longest lock drop
    localparam int QUIET_BITS = 64;                  // Bits without transition meaning no carrier
    localparam logic [3:0] BITCNT_ZERO = 4'h0;       // Bit counter reset value
    localparam logic [1:0] WCNT_ZERO = 2'h0;         // Word counter reset value

    // Header search states, Gray coded along the path
    typedef enum logic [1:0] {
        SDR_HUNT = 2'b00,
        SDR_ZERO1 = 2'b01,
        SDR_ZERO2 = 2'b11,
        SDR_XYZ = 2'b10
    } sdr_state_t;

    // Status indications travelling together
    typedef struct packed {
        logic line_blank;
        logic carrier_present_n;
        logic lock;
        logic vco_center;
    } sdr_status_t;
endpackage : sdr_pkg

// ==== sdr_receive.sv ====
// Receive back end: transition decode, descramble, header align, serial to parallel
module sdr_receive #(
    parameter int LOCK_DELAY_CYC = sdr_pkg::LOCK_DELAY_US * (sdr_pkg::BIT_RATE_HZ / 1000000), // Lock delay
    parameter int QUIET_CYC = sdr_pkg::QUIET_BITS                                             // Quiet window
) (
    input wire logic clock,                                  // Recovered bit clock
    input wire logic srst,                                   // Synchronous reset, active high
    input wire logic clk_en,                                 // Clock enable, freezes all state when low
    input wire logic serial_in,                              // Sliced serial bit from the slicer
    input wire logic coding_bypass,                          // High skips decode and descramble
    input wire logic cable_comp_bypass,                      // Equalizer bypass, passed to analog side
    input wire logic pll_locked,                             // Clock recovery lock from the analog loop
    output logic [sdr_pkg::WORD_W-1:0] data_out,             // Parallel word
    output logic word_clock_out,                             // Divided word clock
    output logic line_blank,                                 // Line blanking flag
    output logic carrier_present_n,                          // High when no carrier
    output logic lock,                                       // Lock indication
    output logic vco_center,                                 // Steers oscillator to centre
    output logic eq_bypass_out                               // Registered equalizer bypass to analog
);
    localparam int W = sdr_pkg::WORD_W;
    localparam int LCW = $clog2(LOCK_DELAY_CYC + 1);
    localparam int QCW = $clog2(QUIET_CYC + 1);

    //////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three flops, change counts when stages two and three agree
    // The sliced line is already retimed by the recovered clock, so it only gets one
    // register: a glitch filter would swallow every single-bit symbol of the stream
    logic [2:0] byp_sync;                 // Bypass pin pipeline
    logic [2:0] lck_sync;                 // Lock pin pipeline
    logic ser_bit;                        // Accepted serial level
    logic byp;                            // Accepted bypass level
    logic pll_ok;                         // Accepted lock level

    // Shift pins in; stage one is only read by stage two
    always_ff @(posedge clock) begin
        if (srst) begin
            byp_sync <= 3'h0;
            lck_sync <= 3'h0;
            ser_bit <= 1'b0;
            byp <= 1'b0;
            pll_ok <= 1'b0;
        end else if (clk_en) begin
            byp_sync <= {byp_sync[1:0], coding_bypass};
            lck_sync <= {lck_sync[1:0], pll_locked};
            ser_bit <= serial_in;
            if (byp_sync[1] == byp_sync[2]) byp <= byp_sync[2];
            if (lck_sync[1] == lck_sync[2]) pll_ok <= lck_sync[2];
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Transition decode then descramble, order fixed on the bit clock
    logic prev_line;                      // Previous received line bit
    logic [8:0] scr_hist;                 // Last nine transition-decoded, still scrambled bits
    wire nrz_bit = ser_bit ^ prev_line;
    wire plain_bit = nrz_bit ^ scr_hist[sdr_pkg::TAP_HI] ^ scr_hist[sdr_pkg::TAP_LO];
    wire dec_bit = byp ? ser_bit : plain_bit;

    // History of line bits and of the scrambled stream
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_line <= 1'b0;
            scr_hist <= sdr_pkg::SCR_INIT;
        end else if (clk_en) begin
            prev_line <= ser_bit;
            scr_hist <= {scr_hist[7:0], nrz_bit}; // Self-synchronising: fed by received bits
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Shift register and header search
    logic [W-1:0] shift;                  // Newest bit at the top, LSB first on the line
    logic [3:0] bit_cnt;                  // Run of ones counter
    logic [1:0] word_cnt;                 // Zero words of the preamble seen
    logic [3:0] div_cnt;                  // Divide by ten phase
    sdr_pkg::sdr_state_t state;           // Header search state
    logic sm_clear;                       // State machine override that keeps the bit counter out of reset
    logic [3:0] zero_cnt;                 // Zeros of the current preamble word

    // Word counter value after the first zero word
    function automatic logic [1:0] wcnt_one();
        return 2'h1;
    endfunction : wcnt_one

    wire [W-1:0] next_shift = {dec_bit, shift[W-1:1]};
    wire bitcnt_rst_n = dec_bit | sm_clear;
    wire ones_run = bit_cnt == sdr_pkg::DIV_LAST;
    wire zero_word = next_shift == sdr_pkg::TRS_ZEROS;
    wire word_done = div_cnt == sdr_pkg::DIV_LAST;
    wire zero_last = !dec_bit && (zero_cnt == sdr_pkg::DIV_LAST);           // Tenth zero of a word
    wire hdr_found = (state == sdr_pkg::SDR_ZERO1) && zero_word && zero_last && (word_cnt == wcnt_one());
    wire readout = div_cnt == sdr_pkg::DIV_READOUT;

    // Bit counter counts consecutive ones; zero data holds it in reset unless sm_clear is high
    always_ff @(posedge clock) begin
        if (srst) begin
            bit_cnt <= sdr_pkg::BITCNT_ZERO;
            shift <= '0;
        end else if (clk_en) begin
            shift <= next_shift;
            if (!bitcnt_rst_n) bit_cnt <= sdr_pkg::BITCNT_ZERO;
            else if (!ones_run) bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // Controlling state machine with word counter
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= sdr_pkg::SDR_HUNT;
            word_cnt <= sdr_pkg::WCNT_ZERO;
            zero_cnt <= sdr_pkg::BITCNT_ZERO;
            sm_clear <= 1'b0;
        end else if (clk_en) begin
            sm_clear <= 1'b0;                       // Normally low
            unique case (state)
                sdr_pkg::SDR_HUNT: begin            // Ten ones in a row open a preamble
                    zero_cnt <= sdr_pkg::BITCNT_ZERO;
                    if (ones_run && dec_bit) begin
                        state <= sdr_pkg::SDR_ZERO1;
                        word_cnt <= sdr_pkg::WCNT_ZERO;
                    end
                end
                sdr_pkg::SDR_ZERO1: begin           // Wait for twenty zeros, counted as words
                    if (dec_bit) begin
                        zero_cnt <= sdr_pkg::BITCNT_ZERO;
                        if (!ones_run) state <= sdr_pkg::SDR_HUNT; // Broken run
                    end else if (zero_last) begin
                        zero_cnt <= sdr_pkg::BITCNT_ZERO;
                        if (hdr_found) state <= sdr_pkg::SDR_ZERO2; // Second zero word: header aligned
                        else word_cnt <= wcnt_one();
                    end else begin
                        zero_cnt <= zero_cnt + 4'h1;
                    end
                end
                sdr_pkg::SDR_ZERO2: begin           // Header now word aligned, collect XYZ word
                    if (word_done) state <= sdr_pkg::SDR_XYZ;
                end
                sdr_pkg::SDR_XYZ: begin             // Word complete in the shift register
                    state <= sdr_pkg::SDR_HUNT;
                    sm_clear <= 1'b1;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Word clock divider and parallel outputs
    logic [W-1:0] word_hold;              // Word taken at the readout strobe
    // Divider restarts on a header in the same cycle it is seen
    always_ff @(posedge clock) begin
        if (srst) begin
            div_cnt <= sdr_pkg::DIV_INIT;
            word_clock_out <= 1'b0;
            word_hold <= '0;
            data_out <= '0;
        end else if (clk_en) begin
            if (hdr_found || word_done) div_cnt <= sdr_pkg::DIV_INIT;
            else div_cnt <= div_cnt + 4'h1;
            word_clock_out <= div_cnt < sdr_pkg::DIV_HALF;
            if (readout) word_hold <= shift;
            if (div_cnt == sdr_pkg::DIV_HALF) data_out <= word_hold;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Blanking flag, carrier and lock indications
    logic [QCW-1:0] quiet_cnt;            // Bits since the last transition
    logic [LCW-1:0] lock_cnt;             // Delay before lock is shown
    wire edge_seen = ser_bit ^ prev_line;
    // Flag follows the H bit of the word after the preamble; meaningless in bypass
    always_ff @(posedge clock) begin
        if (srst) begin
            line_blank <= 1'b0;
            quiet_cnt <= '0;
            carrier_present_n <= 1'b1;
            vco_center <= 1'b1;
            lock_cnt <= '0;
            lock <= 1'b0;
            eq_bypass_out <= 1'b0;
        end else if (clk_en) begin
            eq_bypass_out <= cable_comp_bypass;
            // The hold register is loaded on this same edge, so the flag reads the shift register
            if (state == sdr_pkg::SDR_XYZ) line_blank <= shift[sdr_pkg::H_BIT];
            if (edge_seen) quiet_cnt <= '0;
            else if (quiet_cnt != QCW'(QUIET_CYC)) quiet_cnt <= quiet_cnt + 1'b1;
            carrier_present_n <= !edge_seen && (quiet_cnt == QCW'(QUIET_CYC));
            vco_center <= !edge_seen && (quiet_cnt == QCW'(QUIET_CYC));
            // Lock drops with the loop; brief drops are tolerated downstream
            if (!pll_ok) lock_cnt <= '0;
            else if (lock_cnt != LCW'(LOCK_DELAY_CYC)) lock_cnt <= lock_cnt + 1'b1;
            lock <= pll_ok && (lock_cnt == LCW'(LOCK_DELAY_CYC));
        end
    end
endmodule : sdr_receive

// ==== sdr_props.sv ====
// Checker: port properties of the receive back end
module sdr_props #(parameter int LOCK_DELAY_CYC = 20, parameter int QUIET_CYC = 8) (
    input wire logic clock, // Bit clock
    input wire logic srst, // Reset
    input wire logic serial_in, // Line
    input wire logic pll_locked, // Loop lock
    input wire logic [sdr_pkg::WORD_W-1:0] data_out, // Word
    input wire logic word_clock_out, // Word clock
    input wire logic line_blank, // Blank flag
    input wire logic carrier_present_n, // No carrier
    input wire logic lock // Lock
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    int quiet_cnt, lock_cnt; // Pin run lengths; the design sees them a few syncs late
    always_ff @(posedge clock) begin // Cycles since last transition, and with loop locked
        quiet_cnt <= (srst || $changed(serial_in)) ? 0 : quiet_cnt + 1;
        lock_cnt <= (srst || !pll_locked) ? 0 : lock_cnt + 1;
    end
    property p_wclk_high; $rose(word_clock_out) |-> word_clock_out [*5]; endproperty
    a_wclk_high: assert property (p_wclk_high) else $error("word clock high too short");
    property p_wclk_low; $fell(word_clock_out) |-> ##[1:5] word_clock_out; endproperty
    a_wclk_low: assert property (p_wclk_low) else $error("word clock low too long");
    property p_data_fall; $changed(data_out) |-> !word_clock_out; endproperty
    a_data_fall: assert property (p_data_fall) else $error("word moved with word clock high");
    property p_blank; $changed(line_blank) |-> ##5 line_blank == data_out[sdr_pkg::H_BIT]; endproperty
    a_blank: assert property (p_blank) else $error("blank flag not from header word");
    property p_carrier_low; $changed(serial_in) |-> ##[1:8] !carrier_present_n; endproperty
    a_carrier_low: assert property (p_carrier_low) else $error("carrier not shown");
    property p_carrier_high; $rose(carrier_present_n) |-> quiet_cnt >= QUIET_CYC; endproperty
    a_carrier_high: assert property (p_carrier_high) else $error("carrier lost too soon");
    property p_lock_rise; $rose(lock) |-> lock_cnt >= LOCK_DELAY_CYC; endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock rose early");
    property p_lock_drop; !pll_locked [*6] |-> !lock; endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock held without loop lock");
endmodule : sdr_props
bind sdr_receive sdr_props #(.LOCK_DELAY_CYC(LOCK_DELAY_CYC), .QUIET_CYC(QUIET_CYC)) sdr_props_i (.clock(clock),
    .srst(srst), .serial_in(serial_in), .pll_locked(pll_locked), .data_out(data_out), .word_clock_out(word_clock_out),
    .line_blank(line_blank), .carrier_present_n(carrier_present_n), .lock(lock));

// ==== sdr_tx_model.sv ====
// Partner: transmitter that scrambles and transition-codes words onto the line
module sdr_tx_model (
    input wire logic clock, // Bit clock
    output logic serial_out // Line level, held between words so an idle line has no transitions
);
    timeunit 1ns / 1ps;
    logic [8:0] hist = sdr_pkg::SCR_INIT; // Past scrambled bits, newest in bit 0
    initial serial_out = 1'b0;
    // Send one word LSB first, each bit 1 ns after an edge; raw skips both codes
    task automatic send(input logic [sdr_pkg::WORD_W-1:0] w, input logic raw);
        for (int i = 0; i < sdr_pkg::WORD_W; i++) begin
            @(posedge clock);
            #1 hist = {hist[7:0], w[i] ^ hist[sdr_pkg::TAP_LO] ^ hist[sdr_pkg::TAP_HI]}; // Scrambler
            serial_out = raw ? w[i] : serial_out ^ hist[0]; // Transition code x + 1
        end
    endtask : send
endmodule : sdr_tx_model

// ==== sdr_receive_test.sv ====
// Testbench: receive back end fed by the transmitter model
module sdr_receive_test;
    timeunit 1ns / 1ps;
    localparam int LOCK_CYC = 20; // Short lock delay keeps the run brief
    logic clock = 1'b0; // Bit clock
    logic srst = 1'b1; // Reset
    logic coding_bypass = 1'b0, cable_comp_bypass = 1'b0; // Mode inputs
    logic pll_locked = 1'b0; // Loop lock
    logic serial_in; // Line
    logic [sdr_pkg::WORD_W-1:0] data_out; // Word
    logic word_clock_out, line_blank, carrier_present_n, lock, vco_center, eq_bypass_out; // Outputs
    int n_fail = 0, n_compared = 0; // Counters
    always #25 clock = ~clock; // 50 ns period
    sdr_receive #(.LOCK_DELAY_CYC(LOCK_CYC), .QUIET_CYC(8)) sdr_receive_i (.clock(clock), .srst(srst), .clk_en(1'b1),
        .serial_in(serial_in), .coding_bypass(coding_bypass), .cable_comp_bypass(cable_comp_bypass),
        .pll_locked(pll_locked), .data_out(data_out), .word_clock_out(word_clock_out), .line_blank(line_blank),
        .carrier_present_n(carrier_present_n), .lock(lock), .vco_center(vco_center), .eq_bypass_out(eq_bypass_out));
    sdr_tx_model sdr_tx_model_i (.clock(clock), .serial_out(serial_in));
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [sdr_pkg::WORD_W-1:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check
    // Main sequence; inputs move 1 ns after the edge
    initial begin
        logic [sdr_pkg::WORD_W-1:0] seq [11]; // Words sent per header pass
        repeat (6) @(posedge clock);
        #1 srst = 1'b0;
        check({5'h00, lock, line_blank, carrier_present_n, vco_center, eq_bypass_out}, 10'h006, "reset flags");
        // Lock qualifies after its delay and drops with the loop
        pll_locked = 1'b1;
        repeat (LOCK_CYC + 8) @(posedge clock);
        #1 check({9'h000, lock}, 10'h001, "lock not raised");
        pll_locked = 1'b0;
        repeat (6) @(posedge clock);
        #1 check({9'h000, lock}, 10'h000, "lock not dropped");
        // End then start header, framed by filler words that expose word alignment
        for (int h = 1; h >= 0; h--) begin
            seq = '{10'h1C3, 10'h1C3, 10'h1C3, sdr_pkg::TRS_ONES, sdr_pkg::TRS_ZEROS, sdr_pkg::TRS_ZEROS,
                h ? 10'h274 : 10'h200, 10'h1C3, 10'h1C3, 10'h1C3, 10'h1C3};
            foreach (seq[i]) sdr_tx_model_i.send(seq[i], 1'b0);
            check(data_out, 10'h1C3, "word not aligned");
            check({8'h00, line_blank, carrier_present_n}, {8'h00, h[0], 1'b0}, "blank or carrier");
        end
        // Bypass: raw ones reach the word unchanged and leave the line without transitions
        coding_bypass = 1'b1;
        cable_comp_bypass = 1'b1;
        repeat (6) sdr_tx_model_i.send(10'h3FF, 1'b1);
        check(data_out, 10'h3FF, "bypass word");
        check({7'h00, carrier_present_n, vco_center, eq_bypass_out}, 10'h007, "idle line flags");
        end_of_test();
    end
endmodule : sdr_receive_test
